// *** hw/acp_core.sv ***
// multiply-accumulate coprocessor datapath with result registers and result-read modes
`timescale 1ns/100ps
// Notes on behaviour
// - accumulate mode adds operand product to result zero
// - clear mode zeroes both result registers at once
// - 16-bit init loads low half, clears top
// - 32-bit init loads first high, second low
// - 0x06 unsigned, 0x07 signed, return low half
// - 0x16/0x17 accumulate, return high half
// - overflow returns flag pattern 0b0100
// - only signed accumulation can report overflow
// - same-sign addends with opposite-sign sum overflow
// - overflow keeps stored accumulator for that operation only
// - clean accumulate, or load/operate outside read modes, clears overflow
// - 0x03/0x13 read low/high of result zero
// - 0x23/0x33 read low/high of result one
// - result-read returns zero flags, registers untouched
// - result registers hold value until overwritten
module acp_core
  import acp_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mode_set_valid,
  input wire logic [acp_pkg::MODE_W-1:0] mode_set_value,
  input wire logic load_valid,
  input wire logic [acp_pkg::HALF_W-1:0] load_first,
  input wire logic [acp_pkg::HALF_W-1:0] load_second,
  input wire logic operate_valid,
  input wire logic [acp_pkg::HALF_W-1:0] operate_first,
  input wire logic [acp_pkg::HALF_W-1:0] operate_second,
  output logic result_valid,
  output logic [acp_pkg::HALF_W-1:0] result_data,
  output logic [acp_pkg::FLAG_W-1:0] condition_flag_group,
  output logic overflow,
  output logic busy,
  output logic [acp_pkg::MODE_W-1:0] mode
);
  import acp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [HALF_W-1:0] pick_half(input logic [WORD_W-1:0] val, input logic hi);
    pick_half = hi ? val[WORD_W-1:HALF_W] : val[HALF_W-1:0];
  endfunction

  function automatic logic [WORD_W-1:0] magnitude(input logic [WORD_W-1:0] val, input logic use_sign);
    magnitude = (use_sign && val[WORD_W-1]) ? WORD_W'(-val) : val;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic [WORD_W-1:0] result_reg_zero;
  logic [WORD_W-1:0] result_reg_one;
  acp_state_t state;
  logic is_mac;
  logic is_read;
  logic is_div;
  logic is_signed;
  logic take_mode;
  logic take_load;
  logic take_op;

  assign is_mac = (mode == MODE_MAC_U_LO) || (mode == MODE_MAC_S_LO)
                  || (mode == MODE_MAC_U_HI) || (mode == MODE_MAC_S_HI);
  assign is_read = (mode == MODE_READ_R0_LO) || (mode == MODE_READ_R0_HI)
                   || (mode == MODE_READ_R1_LO) || (mode == MODE_READ_R1_HI);
  assign is_div = (mode[7:6] == 2'b00)
                  && ((mode[3:0] == DIV_NIBBLE_U) || (mode[3:0] == DIV_NIBBLE_S));
  assign is_signed = mode[SIGNED_BIT];
  // transfers arriving outside ACP_IDLE are dropped; the host sees busy in both ACP_DIV and ACP_DIV_FIX
  assign take_mode = mode_set_valid && (state == ACP_IDLE);
  assign take_load = load_valid && (state == ACP_IDLE);
  assign take_op = operate_valid && (state == ACP_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // mode register

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      mode <= MODE_RESET;
    else if (take_mode)
      mode <= mode_set_value;
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiply-accumulate arithmetic

  logic [WORD_W-1:0] product;
  logic [WORD_W-1:0] mac_sum;
  logic mac_ovf;
  logic [WORD_W-1:0] mac_kept;

  always_comb
  begin
    if (is_signed)
      product = WORD_W'($signed(operate_first) * $signed(operate_second));
    else
      product = WORD_W'(operate_first * operate_second);
    mac_sum = WORD_W'(result_reg_zero + product);
    // same-sign addends with a result of the other sign; unsigned never reports
    mac_ovf = is_signed && (product[WORD_W-1] == result_reg_zero[WORD_W-1])
              && (mac_sum[WORD_W-1] != product[WORD_W-1]);
    // on overflow the accumulator stays as it was
    mac_kept = mac_ovf ? result_reg_zero : mac_sum;
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider (shares the result registers and the output select)

  logic [WORD_W:0] div_rem;
  logic [WORD_W-1:0] div_quo;
  logic [WORD_W-1:0] div_dvs;
  logic [CNT_W-1:0] div_cnt;
  logic div_neg_q;
  logic div_neg_r;
  logic [WORD_W:0] div_shift;
  logic [WORD_W:0] div_trial;
  logic [WORD_W-1:0] divisor_in;

  assign divisor_in = {operate_first, operate_second};
  assign div_shift = {div_rem[WORD_W-1:0], div_quo[WORD_W-1]};
  assign div_trial = div_shift - {1'b0, div_dvs};

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state <= ACP_IDLE;
    else
      case (state)
        ACP_IDLE:
          if (take_op && is_div)
            state <= ACP_DIV;
        ACP_DIV:
          if (div_cnt == CNT_W'(DIV_STEPS - 1))
            state <= ACP_DIV_FIX;
        ACP_DIV_FIX:
          state <= ACP_IDLE;
        default:
          state <= ACP_IDLE;
      endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      div_rem <= '0;
      div_quo <= '0;
      div_dvs <= '0;
      div_cnt <= '0;
      div_neg_q <= 1'b0;
      div_neg_r <= 1'b0;
    end
    else if (state == ACP_IDLE && take_op && is_div)
    begin
      div_rem <= '0;
      div_quo <= magnitude(result_reg_zero, is_signed);
      div_dvs <= magnitude(divisor_in, is_signed);
      div_cnt <= '0;
      div_neg_q <= is_signed && (result_reg_zero[WORD_W-1] ^ divisor_in[WORD_W-1]);
      div_neg_r <= is_signed && result_reg_zero[WORD_W-1];
    end
    else if (state == ACP_DIV)
    begin
      div_cnt <= CNT_W'(div_cnt + 1'b1);
      if (!div_trial[WORD_W])
      begin
        div_rem <= div_trial;
        div_quo <= {div_quo[WORD_W-2:0], 1'b1};
      end
      else
      begin
        div_rem <= div_shift;
        div_quo <= {div_quo[WORD_W-2:0], 1'b0};
      end
    end
  end

  logic [WORD_W-1:0] quo_final;
  logic [WORD_W-1:0] rem_final;

  assign quo_final = div_neg_q ? WORD_W'(-div_quo) : div_quo;
  assign rem_final = div_neg_r ? WORD_W'(-div_rem[WORD_W-1:0]) : div_rem[WORD_W-1:0];

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      busy <= 1'b0;
    else
      busy <= (state == ACP_IDLE) ? (take_op && is_div) : (state == ACP_DIV);
  end

  ////////////////////////////////////////////////////////////////////////////
  // result registers; untouched in every case not listed, so they hold
  // their value for repeated reads

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      result_reg_zero <= RESULT_RESET;
      result_reg_one <= RESULT_RESET;
    end
    else if (take_mode && mode_set_value == MODE_CLEAR)
    begin
      result_reg_zero <= RESULT_RESET;
      result_reg_one <= RESULT_RESET;
    end
    else if (take_load && mode == MODE_INIT16)
      result_reg_zero <= {{HALF_W{1'b0}}, load_second};
    else if (take_load && mode == MODE_INIT32)
      result_reg_zero <= {load_first, load_second};
    else if (take_op && is_mac)
      result_reg_zero <= mac_kept;
    else if (state == ACP_DIV_FIX)
    begin
      result_reg_zero <= quo_final;
      result_reg_one <= rem_final;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow flag

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      overflow <= 1'b0;
    else if (take_op && is_mac)
      overflow <= mac_ovf;
    else if ((take_op || take_load) && !is_read)
      overflow <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // returned half-word and flags, one cycle after the operate transfer, or after ACP_DIV_FIX for division

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      result_valid <= 1'b0;
      result_data <= '0;
      condition_flag_group <= FLAGS_NONE;
    end
    else
    begin
      result_valid <= 1'b0;
      if (take_op && is_mac)
      begin
        result_valid <= 1'b1;
        result_data <= pick_half(mac_kept, mode[SEL_HALF_BIT]);
        condition_flag_group <= mac_ovf ? FLAGS_OVERFLOW : FLAGS_NONE;
      end
      else if (take_op && is_read)
      begin
        result_valid <= 1'b1;
        result_data <= pick_half(mode[SEL_REG_BIT] ? result_reg_one : result_reg_zero,
                                 mode[SEL_HALF_BIT]);
        condition_flag_group <= FLAGS_NONE;
      end
      else if (take_op && !is_div)
      begin
        // operate in an init mode has nothing to compute; it echoes the low half
        result_valid <= 1'b1;
        result_data <= pick_half(result_reg_zero, 1'b0);
        condition_flag_group <= FLAGS_NONE;
      end
      else if (state == ACP_DIV_FIX)
      begin
        result_valid <= 1'b1;
        result_data <= pick_half(mode[SEL_REG_BIT] ? rem_final : quo_final, mode[SEL_HALF_BIT]);
        condition_flag_group <= FLAGS_NONE;
      end
    end
  end
endmodule

// *** common/acp_pkg.sv ***
// shared constants for the multiply-accumulate coprocessor datapath
package acp_pkg;
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  localparam int MODE_W = 8;
  localparam int FLAG_W = 4;
  // mode codes
  localparam logic [MODE_W-1:0] MODE_CLEAR = 8'h00;
  localparam logic [MODE_W-1:0] MODE_INIT16 = 8'h01;
  localparam logic [MODE_W-1:0] MODE_INIT32 = 8'h02;
  localparam logic [MODE_W-1:0] MODE_READ_R0_LO = 8'h03;
  localparam logic [MODE_W-1:0] MODE_READ_R0_HI = 8'h13;
  localparam logic [MODE_W-1:0] MODE_READ_R1_LO = 8'h23;
  localparam logic [MODE_W-1:0] MODE_READ_R1_HI = 8'h33;
  localparam logic [MODE_W-1:0] MODE_MAC_U_LO = 8'h06;
  localparam logic [MODE_W-1:0] MODE_MAC_S_LO = 8'h07;
  localparam logic [MODE_W-1:0] MODE_MAC_U_HI = 8'h16;
  localparam logic [MODE_W-1:0] MODE_MAC_S_HI = 8'h17;
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;
  // division family: low nibble 8 (unsigned) or 9 (signed), bit 5 picks quotient/remainder, bit 4 output half
  localparam logic [3:0] DIV_NIBBLE_U = 4'h8;
  localparam logic [3:0] DIV_NIBBLE_S = 4'h9;
  // output select field position within the mode value
  localparam int SEL_HALF_BIT = 4;
  localparam int SEL_REG_BIT = 5;
  localparam int SIGNED_BIT = 0;
  // condition_flag_group order: carry, overflow, zero, negative (msb first)
  localparam logic [FLAG_W-1:0] FLAGS_OVERFLOW = 4'b0100;
  localparam logic [FLAG_W-1:0] FLAGS_NONE = 4'b0000;
  // reset values
  localparam logic [WORD_W-1:0] RESULT_RESET = 32'h0000_0000;
  // restoring divider takes one cycle per quotient bit
  localparam int DIV_STEPS = WORD_W;
  localparam int CNT_W = 6;
  typedef enum logic [1:0] {ACP_IDLE, ACP_DIV, ACP_DIV_FIX} acp_state_t;
endpackage

// *** tb/acp_monitor.sv ***
// concurrent checks on the coprocessor datapath ports
`timescale 1ns/100ps
module acp_monitor
  import acp_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mode_set_valid,
  input wire logic [acp_pkg::MODE_W-1:0] mode_set_value,
  input wire logic load_valid,
  input wire logic operate_valid,
  input wire logic result_valid,
  input wire logic [acp_pkg::FLAG_W-1:0] condition_flag_group,
  input wire logic overflow,
  input wire logic busy,
  input wire logic [acp_pkg::MODE_W-1:0] mode
);
  logic op_go;
  logic rd_mode;
  logic mac_mode;
  // division modes answer late, so they are kept out of the one-cycle check
  assign op_go = operate_valid && !busy;
  // only the four listed read codes leave overflow alone; other codes ending in 3 are not reads
  assign rd_mode = mode inside {MODE_READ_R0_LO, MODE_READ_R0_HI, MODE_READ_R1_LO, MODE_READ_R1_HI};
  assign mac_mode = mode inside {MODE_MAC_U_LO, MODE_MAC_S_LO, MODE_MAC_U_HI, MODE_MAC_S_HI};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  chk_op_answer: assert property (op_go && mode[3:1] != 3'b100 |=> result_valid)
    else $error("operate gave no answer");
  chk_read_flags: assert property (op_go && rd_mode |=> result_valid && condition_flag_group == FLAGS_NONE)
    else $error("read mode flags not zero");
  chk_read_keeps: assert property (op_go && rd_mode |=> $stable(overflow))
    else $error("read mode changed overflow");
  chk_unsigned_clean: assert property (op_go && mode[0] == 1'b0 && mac_mode |=> !overflow)
    else $error("unsigned accumulate overflowed");
  chk_ovf_flags: assert property ($rose(overflow) |-> result_valid && condition_flag_group == FLAGS_OVERFLOW)
    else $error("overflow flag pattern wrong");
  chk_clean_flags: assert property (op_go && mac_mode ##1 !overflow |-> condition_flag_group == FLAGS_NONE)
    else $error("clean accumulate flags not zero");
  chk_load_clears: assert property (load_valid && !busy && !rd_mode |=> !overflow)
    else $error("load left overflow set");
  chk_mode_load: assert property (mode_set_valid && !busy |=> mode == $past(mode_set_value))
    else $error("mode register not updated");
  cover property (op_go && mac_mode);
  cover property ($rose(overflow));
  cover property (op_go && mode == MODE_READ_R1_HI);
  cover property ($rose(busy));
endmodule
bind acp_core acp_monitor u_acp_monitor (.mclk, .sys_rst, .mode_set_valid, .mode_set_value, .load_valid,
  .operate_valid, .result_valid, .condition_flag_group, .overflow, .busy, .mode);

// *** tb/acp_host.sv ***
// host core model issuing mode-set, load and operate transfers
`timescale 1ns/100ps
module acp_host
  import acp_pkg::*;
(
  input wire logic mclk,
  output logic mode_set_valid,
  output logic [acp_pkg::MODE_W-1:0] mode_set_value,
  output logic load_valid,
  output logic [acp_pkg::HALF_W-1:0] load_first,
  output logic [acp_pkg::HALF_W-1:0] load_second,
  output logic operate_valid,
  output logic [acp_pkg::HALF_W-1:0] operate_first,
  output logic [acp_pkg::HALF_W-1:0] operate_second
);
  initial
  begin
    {mode_set_valid, load_valid, operate_valid} = 3'b000;
    {mode_set_value, load_first, load_second, operate_first, operate_second} = '0;
  end
  // mode always goes out before its data; k: 0 none, 1 load, 2 operate
  // released buses show inverted data so stale values never pass
  task automatic send(input logic [7:0] m, input int k, input logic [15:0] a, input logic [15:0] b);
    @(posedge mclk);
    mode_set_valid <= 1'b1;
    mode_set_value <= m;
    @(posedge mclk);
    mode_set_valid <= 1'b0;
    mode_set_value <= ~m;
    load_valid <= k == 1;
    operate_valid <= k == 2;
    {load_first, load_second, operate_first, operate_second} <= {a, b, a, b};
    if (k != 0)
    begin
      @(posedge mclk);
      {load_valid, operate_valid} <= 2'b00;
      {load_first, load_second, operate_first, operate_second} <= ~{a, b, a, b};
    end
  endtask
endmodule

// *** tb/tb_acp_core.sv ***
// self-checking bench for the multiply-accumulate datapath
`timescale 1ns/100ps
module tb_acp_core;
  import acp_pkg::*;
  typedef struct {logic [7:0] m; logic [15:0] a; logic [15:0] b; logic [15:0] d; logic [3:0] f; logic o;} acp_row_t;
  logic mclk, sys_rst, mode_set_valid, load_valid, operate_valid, result_valid, overflow, busy;
  logic [MODE_W-1:0] mode_set_value, mode;
  logic [HALF_W-1:0] load_first, load_second, operate_first, operate_second, result_data;
  logic [FLAG_W-1:0] condition_flag_group;
  int mismatches = 0;
  int checked = 0;
  // each row: mode, operands, expected half word, flags, overflow
  acp_row_t rows [23] = '{
    '{8'h02, 16'h1234, 16'h5678, 16'h0, 4'h0, 1'b0}, '{8'h13, 16'h0, 16'h0, 16'h1234, 4'h0, 1'b0},
    '{8'h03, 16'h0, 16'h0, 16'h5678, 4'h0, 1'b0}, '{8'h06, 16'hffff, 16'hffff, 16'h5679, 4'h0, 1'b0},
    '{8'h16, 16'h0002, 16'h0003, 16'h1232, 4'h0, 1'b0}, '{8'h01, 16'hffff, 16'h8001, 16'h0, 4'h0, 1'b0},
    '{8'h13, 16'h0, 16'h0, 16'h0000, 4'h0, 1'b0}, '{8'h07, 16'h0003, 16'hfffe, 16'h7ffb, 4'h0, 1'b0},
    '{8'h02, 16'h7fff, 16'hffff, 16'h0, 4'h0, 1'b0}, '{8'h07, 16'h0001, 16'h0001, 16'hffff, 4'h4, 1'b1},
    '{8'h13, 16'h0, 16'h0, 16'h7fff, 4'h0, 1'b1}, '{8'h17, 16'h0, 16'h0, 16'h7fff, 4'h0, 1'b0},
    '{8'h02, 16'h8000, 16'h0000, 16'h0, 4'h0, 1'b0}, '{8'h07, 16'hffff, 16'h0001, 16'h0000, 4'h4, 1'b1},
    '{8'h01, 16'h0, 16'h0005, 16'h0, 4'h0, 1'b0}, '{8'h02, 16'h0000, 16'h0064, 16'h0, 4'h0, 1'b0},
    '{8'h08, 16'h0000, 16'h0007, 16'h000e, 4'h0, 1'b0}, '{8'h23, 16'h0, 16'h0, 16'h0002, 4'h0, 1'b0},
    '{8'h33, 16'h0, 16'h0, 16'h0000, 4'h0, 1'b0}, '{8'h03, 16'h0, 16'h0, 16'h000e, 4'h0, 1'b0},
    '{8'h00, 16'h0, 16'h0, 16'h0, 4'h0, 1'b0}, '{8'h23, 16'h0, 16'h0, 16'h0000, 4'h0, 1'b0},
    '{8'h03, 16'h0, 16'h0, 16'h0000, 4'h0, 1'b0}};
  acp_core u_acp_core (.mclk(mclk), .sys_rst(sys_rst), .mode_set_valid(mode_set_valid),
    .mode_set_value(mode_set_value), .load_valid(load_valid), .load_first(load_first), .load_second(load_second),
    .operate_valid(operate_valid), .operate_first(operate_first), .operate_second(operate_second),
    .result_valid(result_valid), .result_data(result_data), .condition_flag_group(condition_flag_group),
    .overflow(overflow), .busy(busy), .mode(mode));
  acp_host u_acp_host (.mclk(mclk), .mode_set_valid(mode_set_valid), .mode_set_value(mode_set_value),
    .load_valid(load_valid), .load_first(load_first), .load_second(load_second), .operate_valid(operate_valid),
    .operate_first(operate_first), .operate_second(operate_second));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // whole run is about 130 cycles
  initial
  begin
    #50000;
    mismatches++;
    summarize();
  end
  initial
  begin
    int n;
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({8'h0, mode}, {8'h0, MODE_RESET});
    chk({10'h0, result_valid, overflow, busy, 3'h0}, 16'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      if (rows[i].m inside {MODE_INIT16, MODE_INIT32})
        u_acp_host.send(rows[i].m, 1, rows[i].a, rows[i].b);
      else
        u_acp_host.send(rows[i].m, rows[i].m == MODE_CLEAR ? 0 : 2, rows[i].a, rows[i].b);
      if (!(rows[i].m inside {MODE_CLEAR, MODE_INIT16, MODE_INIT32}))
      begin
        // the answer stands one cycle right after the operate edge; division answers later
        n = 0;
        #1;
        while (result_valid !== 1'b1 && n < 60)
        begin
          @(posedge mclk);
          #1;
          n++;
        end
        chk({15'h0, result_valid}, 16'h0001);
        chk(result_data, rows[i].d);
        chk({12'h0, condition_flag_group}, {12'h0, rows[i].f});
      end
      @(posedge mclk);
      #1;
      chk({15'h0, overflow}, {15'h0, rows[i].o});
    end
    $display("row test done");
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({8'h0, mode}, {8'h0, MODE_RESET});
    $display("mid-run reset test done");
    summarize();
  end
endmodule
